/* File: tb/pmr_monitor.sv */
// Purpose: port checker for pmr_top
// Assumes: one pclk domain
// Notes: bound from testbench
`timescale 1ns/1ps
`default_nettype none
module pmr_monitor
    import pmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hard_reset_n,
    input wire logic [3:0] reference_inputs,
    input wire logic lock_detect,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic clk_out_en,
    input wire logic loss_of_lock,
    input wire logic [4:0] mode,
    input wire logic init_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_take;
        psel && penable && !pready;
    endsequence
    sequence s_init_end;
        $fell(mode == PMR_INIT);
    endsequence
    AST_ONE_MODE: assert property ($onehot(mode)) else $error("mode");
    AST_INIT_DARK: assert property (mode == PMR_INIT [*2] |-> !clk_out_en)
        else $error("clk in init");
    AST_ANSWER: assert property (s_take |=> pready) else $error("no pready");
    AST_INIT_REFUSE: assert property (s_take ##0 mode == PMR_INIT |=> pslverr)
        else $error("init access");
    AST_FREERUN: assert property (s_init_end |-> mode == PMR_FREERUN)
        else $error("no freerun");
    AST_PIN_RESET: assert property (!hard_reset_n |-> ##[1:2] (mode == PMR_INIT))
        else $error("pin reset");
    AST_LOCK_CAUSE: assert property ($rose(mode == PMR_LOCKED) |-> $past(lock_detect))
        else $error("lock cause");
    AST_LOL: assert property (mode == PMR_LOCKED [*2] |-> !loss_of_lock)
        else $error("lol");
    AST_HOLD: assert property (mode == PMR_LOCKED && reference_inputs == 4'h0
        |-> ##[1:3] mode == PMR_HOLDOVER) else $error("no holdover");
endmodule : pmr_monitor
`default_nettype wire

/* File: tb/pmr_ref_model.sv */
// Purpose: reference inputs and lock detector
// Assumes: one-hot mode from pmr_pkg
// Notes: lock_delay picks prompt or slow lock
`timescale 1ns/1ps
`default_nettype none
module pmr_ref_model
    import pmr_pkg::*;
(
    input wire logic pclk,
    input wire logic [3:0] valid_mask,
    input wire logic [7:0] lock_delay,
    input wire logic [4:0] mode,
    output logic [3:0] reference_inputs,
    output logic lock_detect
);
    logic [7:0] cnt_q;
    logic pulling;
    assign pulling = mode == PMR_ACQUIRE || mode == PMR_LOCKED;
    assign reference_inputs = valid_mask;
    assign lock_detect = pulling && cnt_q >= lock_delay;
    always_ff @(posedge pclk) begin
        cnt_q <= pulling ? cnt_q + {7'h00, cnt_q != 8'hFF} : 8'h00;
    end
endmodule : pmr_ref_model
`default_nettype wire

/* File: tb/testbench.sv */
// Purpose: directed test of pmr_top
// Assumes: apb answers with one wait state
// Notes: expectations from the store image
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import pmr_pkg::*;
    logic pclk = 0, presetn = 0, hard_reset_n = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, clk_out_en, loss_of_lock, init_done, lock_detect, er;
    logic [4:0] loop_bw, mode;
    logic [1:0] ref_sel;
    logic [3:0] ref_in, mask = 4'h0;
    logic [7:0] dly = 8'h20;
    int err_total = 0, num_checks = 0, cyc = 0;
    always #20 pclk = ~pclk;
    pmr_top DUT (.pclk(pclk), .presetn(presetn), .hard_reset_n(hard_reset_n),
        .reference_inputs(ref_in), .lock_detect(lock_detect), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_out_en(clk_out_en), .loss_of_lock(loss_of_lock),
        .loop_bw(loop_bw), .ref_sel(ref_sel), .mode(mode), .init_done(init_done));
    pmr_ref_model u_ref (.pclk(pclk), .valid_mask(mask), .lock_delay(dly), .mode(mode),
        .reference_inputs(ref_in), .lock_detect(lock_detect));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wait_mode(input logic [4:0] m);
        for (int i = 0; i < 300 && mode !== m; i++) @(posedge pclk);
        repeat (2) @(posedge pclk);
        chk(mode, m);
    endtask : wait_mode
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, PMR_OFF_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk({er, clk_out_en, mode}, {1'b1, 1'b0, PMR_INIT});
        wait_mode(PMR_FREERUN);
        chk(clk_out_en, 1'b1);
        xfer(1'b0, PMR_OFF_CTRL, 32'h0);
        chk(rd, PMR_STORE_CTRL_RST);
        xfer(1'b0, PMR_OFF_BW, 32'h0);
        chk(rd, PMR_STORE_BW_RST);
        xfer(1'b0, 12'h020, 32'h0);
        chk(er, 1'b1);
        mask <= 4'h4;
        wait_mode(PMR_ACQUIRE);
        chk({ref_sel, loop_bw}, {2'h2, 5'h0C});
        wait_mode(PMR_LOCKED);
        chk({loss_of_lock, loop_bw}, {1'b0, 5'h04});
        mask <= 4'h0;
        wait_mode(PMR_HOLDOVER);
        dly <= 8'h01;
        mask <= 4'hA;
        wait_mode(PMR_LOCKED);
        chk(ref_sel, 2'h1);
        xfer(1'b1, PMR_OFF_BW, 32'h0100);
        xfer(1'b0, PMR_OFF_BW, 32'h0);
        chk(rd, 32'h0A00);
        xfer(1'b1, PMR_OFF_BW, 32'h1F1F);
        xfer(1'b0, PMR_OFF_BW, 32'h0);
        chk(rd, 32'h1010);
        xfer(1'b1, PMR_OFF_FREQ, 32'h1234);
        xfer(1'b1, PMR_OFF_CTRL, 32'h0E);
        xfer(1'b0, PMR_OFF_STORE, 32'h0);
        chk({init_done, rd}, {1'b1, 32'h1234});
        xfer(1'b1, PMR_OFF_CTRL, 32'h4C);
        xfer(1'b1, PMR_OFF_BW, 32'h0A04);
        mask <= 4'h0;
        xfer(1'b1, PMR_OFF_CTRL, 32'h0D);
        @(negedge pclk);
        chk(init_done, 1'b0);
        wait_mode(PMR_FREERUN);
        xfer(1'b0, PMR_OFF_BW, 32'h0);
        chk(rd, 32'h1010);
        xfer(1'b1, PMR_OFF_BW, 32'h0A04);
        hard_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        hard_reset_n <= 1'b1;
        chk(init_done, 1'b0);
        wait_mode(PMR_FREERUN);
        xfer(1'b0, PMR_OFF_BW, 32'h0);
        chk(rd, 32'h1010);
        report_and_stop();
    end
endmodule : testbench
bind pmr_top pmr_monitor u_mon (.pclk(pclk), .presetn(presetn), .hard_reset_n(hard_reset_n),
    .reference_inputs(reference_inputs), .lock_detect(lock_detect), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .clk_out_en(clk_out_en),
    .loss_of_lock(loss_of_lock), .mode(mode), .init_done(init_done));
`default_nettype wire

/* File: verilog/pmr_pkg.sv */
// Purpose: shared constants for the loop mode and reset controller
// Assumes: 32-bit apb, word-aligned registers
// Notes: offsets are byte addresses
package pmr_pkg;
    localparam logic [11:0] PMR_OFF_CTRL = 12'h000;
    localparam logic [11:0] PMR_OFF_BW = 12'h004;
    localparam logic [11:0] PMR_OFF_FREQ = 12'h008;
    localparam logic [11:0] PMR_OFF_STATUS = 12'h00C;
    localparam logic [11:0] PMR_OFF_STORE = 12'h010;
    // ctrl fields
    localparam int PMR_CTRL_HARD_RST = 0;
    localparam int PMR_CTRL_SOFT_RST = 1;
    localparam int PMR_CTRL_FASTLOCK_EN = 2;
    localparam int PMR_CTRL_AUTO_SEL = 3;
    localparam int PMR_CTRL_MAN_SEL = 4;
    localparam int PMR_CTRL_STORE_WR = 6;
    // bw fields: normal code [4:0], fast code [12:8]
    localparam int PMR_BW_NORM_LSB = 0;
    localparam int PMR_BW_FAST_LSB = 8;
    localparam logic [4:0] PMR_BW_NORM_MAX = 5'h10; // 0.1 Hz .. 4 kHz
    localparam logic [4:0] PMR_BW_FAST_MIN = 5'h0A; // 100 Hz
    localparam logic [4:0] PMR_BW_FAST_MAX = 5'h10; // 4 kHz
    // config store reset image
    localparam logic [31:0] PMR_STORE_CTRL_RST = 32'h0000_000C;
    localparam logic [31:0] PMR_STORE_BW_RST = 32'h0000_0C04;
    localparam logic [31:0] PMR_STORE_FREQ_RST = 32'h0000_0000;
    localparam logic [7:0] PMR_INIT_CYCLES = 8'h20;
    typedef enum logic [4:0] {
        PMR_INIT = 5'b00001,
        PMR_FREERUN = 5'b00010,
        PMR_ACQUIRE = 5'b00100,
        PMR_LOCKED = 5'b01000,
        PMR_HOLDOVER = 5'b10000
    } pmr_mode_t;
endpackage : pmr_pkg

/* File: verilog/pmr_top.sv */
// Purpose: loop mode, reset and bandwidth control with apb registers
// Assumes: all inputs synchronous to pclk
// Notes: init loads ctrl/bw/freq from the config store image
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module pmr_top
    import pmr_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hard_reset_n,
    input wire logic [3:0] reference_inputs,
    input wire logic lock_detect,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic clk_out_en,
    output logic loss_of_lock,
    output logic [4:0] loop_bw,
    output logic [1:0] ref_sel,
    output logic [4:0] mode,
    output logic init_done
);
    logic hard_rst_q;
    logic [7:0] init_cnt_q;
    pmr_mode_t mode_q;
    pmr_mode_t mode_d;
    logic [31:0] ctrl_q;
    logic [31:0] bw_q;
    logic [31:0] freq_q;
    logic [31:0] act_bw_q;
    logic [31:0] act_freq_q;
    logic [31:0] st_ctrl_q;
    logic [31:0] st_bw_q;
    logic [31:0] st_freq_q;
    logic [1:0] sel_q;
    logic [31:0] rdata_q;
    logic ready_q;
    logic err_q;
    logic oe_q;
    logic lol_q;
    logic [4:0] bw_out_q;

    // clamp bandwidth codes into their legal ranges
    wire [4:0] norm_raw = bw_q[PMR_BW_NORM_LSB +: 5];
    wire [4:0] fast_raw = bw_q[PMR_BW_FAST_LSB +: 5];
    wire [4:0] norm_code = (norm_raw > PMR_BW_NORM_MAX) ? PMR_BW_NORM_MAX : norm_raw;
    wire [4:0] fast_code = (fast_raw < PMR_BW_FAST_MIN) ? PMR_BW_FAST_MIN :
        ((fast_raw > PMR_BW_FAST_MAX) ? PMR_BW_FAST_MAX : fast_raw);

    // bandwidth writes are stored already clamped, so readback and store see legal codes
    wire [4:0] wr_norm_raw = pwdata[PMR_BW_NORM_LSB +: 5];
    wire [4:0] wr_fast_raw = pwdata[PMR_BW_FAST_LSB +: 5];
    wire [4:0] wr_norm = (wr_norm_raw > PMR_BW_NORM_MAX) ? PMR_BW_NORM_MAX : wr_norm_raw;
    wire [4:0] wr_fast = (wr_fast_raw < PMR_BW_FAST_MIN) ? PMR_BW_FAST_MIN :
        ((wr_fast_raw > PMR_BW_FAST_MAX) ? PMR_BW_FAST_MAX : wr_fast_raw);
    wire [31:0] bw_wdata = {19'h0_0000, wr_fast, 3'h0, wr_norm};

    wire initing = (mode_q == PMR_INIT);
    wire any_valid = |reference_inputs;
    wire auto_sel = ctrl_q[PMR_CTRL_AUTO_SEL];
    wire [1:0] man_sel = ctrl_q[PMR_CTRL_MAN_SEL +: 2];
    // lowest-numbered valid input wins in automatic mode
    wire [1:0] auto_pick = reference_inputs[0] ? 2'h0 : reference_inputs[1] ? 2'h1 :
        reference_inputs[2] ? 2'h2 : 2'h3;
    wire [1:0] sel_d = auto_sel ? auto_pick : man_sel;
    wire sel_valid = reference_inputs[sel_q];
    wire can_sync = auto_sel ? any_valid : reference_inputs[man_sel];

    wire access = psel && penable && !ready_q;
    wire bus_ok = !initing;
    wire wr = access && pwrite && bus_ok;
    wire rd = access && !pwrite;
    wire hit_ctrl = paddr == PMR_OFF_CTRL;
    wire hit_bw = paddr == PMR_OFF_BW;
    wire hit_freq = paddr == PMR_OFF_FREQ;
    wire hit_stat = paddr == PMR_OFF_STATUS;
    wire hit_store = paddr == PMR_OFF_STORE;
    wire mapped = hit_ctrl | hit_bw | hit_freq | hit_stat | hit_store;
    wire sw_hard = wr && hit_ctrl && pwdata[PMR_CTRL_HARD_RST];
    wire sw_soft = wr && hit_ctrl && pwdata[PMR_CTRL_SOFT_RST];
    wire sw_store = wr && hit_ctrl && pwdata[PMR_CTRL_STORE_WR];
    wire [31:0] status_word = {17'h0_0000, sel_q, lol_q, oe_q, ~initing, bw_out_q, mode_q};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_q : hit_bw ? bw_q : hit_freq ? freq_q :
        hit_stat ? status_word : hit_store ? act_freq_q : 32'h0000_0000;

    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            PMR_INIT: if (init_cnt_q == PMR_INIT_CYCLES) mode_d = PMR_FREERUN;
            PMR_FREERUN: if (can_sync) mode_d = PMR_ACQUIRE;
            PMR_ACQUIRE: begin
                if (!can_sync) mode_d = PMR_FREERUN;
                else if (lock_detect && sel_valid) mode_d = PMR_LOCKED;
            end
            PMR_LOCKED: begin
                if (!sel_valid && !can_sync) mode_d = PMR_HOLDOVER;
                else if (!sel_valid || !lock_detect) mode_d = PMR_ACQUIRE;
            end
            PMR_HOLDOVER: if (can_sync) mode_d = PMR_ACQUIRE;
            default: mode_d = PMR_INIT;
        endcase
    end

    // registered hard reset request: pin or control bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) hard_rst_q <= 1'b1;
        else hard_rst_q <= !hard_reset_n || sw_hard;
    end

    // config store: nonvolatile image, survives hard reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ctrl_q <= PMR_STORE_CTRL_RST;
            st_bw_q <= PMR_STORE_BW_RST;
            st_freq_q <= PMR_STORE_FREQ_RST;
        end else if (sw_store) begin
            st_ctrl_q <= ctrl_q & ~32'h0000_0043;
            st_bw_q <= bw_q;
            st_freq_q <= freq_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= PMR_INIT;
            init_cnt_q <= 8'h00;
        end else if (hard_rst_q) begin
            mode_q <= PMR_INIT;
            init_cnt_q <= 8'h00;
        end else begin
            mode_q <= mode_d;
            if (initing) init_cnt_q <= init_cnt_q + 8'h01;
        end
    end

    // user registers; loaded from store during init
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0000_0000;
            bw_q <= 32'h0000_0000;
            freq_q <= 32'h0000_0000;
            act_bw_q <= 32'h0000_0000;
            act_freq_q <= 32'h0000_0000;
        end else if (hard_rst_q || initing) begin
            ctrl_q <= st_ctrl_q;
            bw_q <= st_bw_q;
            freq_q <= st_freq_q;
            act_bw_q <= st_bw_q;
            act_freq_q <= st_freq_q;
        end else begin
            if (wr && hit_ctrl) ctrl_q <= pwdata & ~32'h0000_0043;
            if (wr && hit_bw) bw_q <= bw_wdata;
            if (wr && hit_freq) freq_q <= pwdata;
            if (sw_soft) begin
                act_bw_q <= bw_q;
                act_freq_q <= freq_q;
            end
        end
    end

    // active loop bandwidth, selection and status outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= 1'b0;
            lol_q <= 1'b1;
            bw_out_q <= 5'h00;
            sel_q <= 2'h0;
        end else begin
            oe_q <= !hard_rst_q && !initing;
            lol_q <= (mode_d != PMR_LOCKED);
            if (mode_d == PMR_ACQUIRE && ctrl_q[PMR_CTRL_FASTLOCK_EN]) bw_out_q <= fast_code;
            else bw_out_q <= norm_code;
            if (mode_q != PMR_LOCKED && mode_q != PMR_HOLDOVER) sel_q <= sel_d;
            else if (mode_q == PMR_LOCKED && !sel_valid) sel_q <= sel_d;
        end
    end

    // apb slave: one wait state, error when unmapped or during init
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ready_q <= access;
            err_q <= access && (!mapped || !bus_ok);
            rdata_q <= (rd && mapped && bus_ok) ? rd_mux : 32'h0000_0000;
        end
    end

    assign prdata = rdata_q;
    assign pready = ready_q;
    assign pslverr = err_q;
    assign clk_out_en = oe_q;
    assign loss_of_lock = lol_q;
    assign loop_bw = bw_out_q;
    assign ref_sel = sel_q;
    assign mode = mode_q;
    assign init_done = oe_q;
endmodule : pmr_top
`default_nettype wire
